// ==== cso_cmd_order.sv ====
// command ordering gate and command-line fetch engine of a command streamer
// assumes executor, register file and memory all run on clock
// Notes on behaviour
// - memory-reading load, atomic and semaphore commands wait for earlier writes visible.
// - non-posted register write holds the next command until the update acks.
// - immediate load, pipe control, math and register copy write non-posted.
// - load-from-memory posted or non-posted according to its async header bit.
// - register readers see the latest value of earlier non-posted writes.
// - fetch engine prefetches up to eight lines and refills as space frees.
// - advanced prefetch is enabled after reset until software clears it.
// - per-context prefetch enable set by arbitration check and saved with context.
// - advanced prefetch runs only when global and context enables are both set.
// - command fifo holds at most eight 64-byte lines.
`timescale 1ns/1ps
`default_nettype none
`include "cso_consts.svh"

module cso_cmd_order
  import cso_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // command from the executor
  input wire logic cmd_valid,
  input wire cso_cmd_type cmd_type,
  input wire logic cmd_async,
  input wire logic cmd_arb_pf_en,
  output logic cmd_done_q,
  // memory write tracking of earlier commands
  input wire logic mem_wr_issue,
  input wire logic mem_wr_go,
  // register write port
  output logic reg_wr_q,
  output logic reg_wr_posted_q,
  input wire logic reg_wr_ack,
  // prefetch enables and context state
  input wire logic gpf_wr,
  input wire logic gpf_wr_data,
  input wire logic ctx_load,
  input wire logic ctx_load_pf_en,
  output logic ctx_pf_en_q,
  output logic adv_pf_active_q,
  // jumps seen by the preparser and executed by the executor
  input wire logic jump_seen,
  input wire logic [`CSO_ADDR_W-1:0] jump_seen_tgt,
  input wire logic jump_exec,
  input wire logic [`CSO_ADDR_W-1:0] jump_exec_tgt,
  // memory fetch port
  output logic fetch_req_q,
  output logic [`CSO_ADDR_W-1:0] fetch_addr_q,
  input wire logic fetch_gnt,
  input wire logic line_valid,
  input wire logic [`CSO_LINE_BITS-1:0] line_data,
  // fetched lines to the parser
  output logic cl_valid_q,
  output logic [`CSO_LINE_BITS-1:0] cl_data_q,
  input wire logic cl_ready
);

  // command ordering
  cso_state_type state_q, state_d;
  cso_cmd_type cur_q;
  logic async_q;
  logic [`CSO_MEMPEND_W-1:0] mem_pend_q;
  logic gpf_q;

  wire take = (state_q == CSO_ST_IDLE) && cmd_valid;
  wire mem_consumer = (cmd_type == CSO_CMD_REG_LOAD_MEM) || (cmd_type == CSO_CMD_ATOMIC)
    || (cmd_type == CSO_CMD_SEM_WAIT);
  wire mem_block = mem_pend_q != '0;
  wire cur_wr = (cur_q == CSO_CMD_REG_LOAD_MEM) || (cur_q == CSO_CMD_REG_LOAD_IMM)
    || (cur_q == CSO_CMD_REG_COPY) || (cur_q == CSO_CMD_MATH) || (cur_q == CSO_CMD_PIPE_CTRL);
  wire cur_posted = (cur_q == CSO_CMD_REG_LOAD_MEM) && async_q;
  wire run_now = (state_q == CSO_ST_WAIT_MEM) && !mem_block;
  wire take_go = take && !(mem_consumer && mem_block);
  wire take_wr = (cmd_type == CSO_CMD_REG_LOAD_MEM) || (cmd_type == CSO_CMD_REG_LOAD_IMM)
    || (cmd_type == CSO_CMD_REG_COPY) || (cmd_type == CSO_CMD_MATH)
    || (cmd_type == CSO_CMD_PIPE_CTRL);
  wire take_posted = (cmd_type == CSO_CMD_REG_LOAD_MEM) && cmd_async;
  wire issue_wr = (take_go && take_wr) || (run_now && cur_wr);
  wire issue_posted = take_go ? take_posted : cur_posted;
  wire finish = (take_go && !take_wr) || (run_now && !cur_wr) || (issue_wr && issue_posted)
    || ((state_q == CSO_ST_WAIT_REG) && reg_wr_ack);

  always_comb begin
    state_d = state_q;
    case (state_q)
      CSO_ST_IDLE: begin
        if (take && !take_go) begin
          state_d = CSO_ST_WAIT_MEM;
        end else if (issue_wr && !issue_posted) begin
          state_d = CSO_ST_WAIT_REG;
        end
      end
      CSO_ST_WAIT_MEM: begin
        if (run_now) begin
          state_d = (cur_wr && !cur_posted) ? CSO_ST_WAIT_REG : CSO_ST_IDLE;
        end
      end
      CSO_ST_WAIT_REG: begin
        if (reg_wr_ack) begin
          state_d = CSO_ST_IDLE;
        end
      end
      default: state_d = CSO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= CSO_ST_IDLE;
      cur_q <= CSO_CMD_OTHER;
      async_q <= 1'b0;
      cmd_done_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_wr_posted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        cur_q <= cmd_type;
        async_q <= cmd_async;
      end
      cmd_done_q <= finish;
      reg_wr_q <= issue_wr;
      reg_wr_posted_q <= issue_wr && issue_posted;
    end
  end

  // posted memory writes still short of global observation
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_pend_q <= '0;
    end else begin
      mem_pend_q <= mem_pend_q + `CSO_MEMPEND_W'(mem_wr_issue) - `CSO_MEMPEND_W'(mem_wr_go);
    end
  end

  // prefetch enables
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gpf_q <= `CSO_GLOBAL_PF_RST;
      ctx_pf_en_q <= `CSO_CTX_PF_RST;
      adv_pf_active_q <= 1'b0;
    end else begin
      if (gpf_wr) begin
        gpf_q <= gpf_wr_data;
      end
      if (ctx_load) begin
        ctx_pf_en_q <= ctx_load_pf_en;
      end else if (take && (cmd_type == CSO_CMD_ARB_CHECK)) begin
        ctx_pf_en_q <= cmd_arb_pf_en;
      end
      adv_pf_active_q <= gpf_q && ctx_pf_en_q;
    end
  end

  // fetch engine
  logic hold_q;
  logic tgt_pend_q;
  logic [`CSO_ADDR_W-1:0] tgt_q;
  logic [`CSO_CNT_W-1:0] out_q;
  logic [`CSO_CNT_W-1:0] drop_q;
  logic [`CSO_CNT_W-1:0] fifo_cnt;
  logic fifo_out_valid;
  logic [`CSO_LINE_BITS-1:0] fifo_out_data;

  wire flush = jump_exec && hold_q;
  wire [`CSO_CNT_W:0] inflight = {1'b0, fifo_cnt} + {1'b0, out_q};
  wire credit = inflight < (`CSO_CNT_W + 1)'(`CSO_FIFO_DEPTH);
  wire issue = !fetch_req_q && !hold_q && !tgt_pend_q && !flush && credit;
  wire ret_drop = line_valid && (drop_q != '0);
  wire push = line_valid && !ret_drop;
  wire stage_load = !cl_valid_q || cl_ready;
  wire pop = fifo_out_valid && stage_load && !flush;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fetch_req_q <= 1'b0;
      fetch_addr_q <= '0;
      hold_q <= 1'b0;
      tgt_pend_q <= 1'b0;
      tgt_q <= '0;
    end else begin
      fetch_req_q <= fetch_req_q ? !fetch_gnt : issue;
      if (flush) begin
        hold_q <= 1'b0;
        tgt_pend_q <= 1'b1;
        tgt_q <= jump_exec_tgt;
      end else if (jump_seen && adv_pf_active_q) begin
        tgt_pend_q <= 1'b1;
        tgt_q <= jump_seen_tgt;
      end else if (jump_seen) begin
        hold_q <= 1'b1;
      end else if (tgt_pend_q && !fetch_req_q) begin
        tgt_pend_q <= 1'b0;
        fetch_addr_q <= tgt_q;
      end
      if (fetch_req_q && fetch_gnt) begin
        fetch_addr_q <= fetch_addr_q + `CSO_ADDR_W'(`CSO_LINE_BYTES);
      end
    end
  end

  // granted lines still to return, and how many of those belong to a dead path
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
      drop_q <= '0;
    end else begin
      out_q <= out_q + `CSO_CNT_W'(fetch_req_q && fetch_gnt) - `CSO_CNT_W'(line_valid);
      if (flush) begin
        drop_q <= out_q + `CSO_CNT_W'(fetch_req_q) - `CSO_CNT_W'(line_valid);
      end else if (ret_drop) begin
        drop_q <= drop_q - 1'b1;
      end
    end
  end

  // credits keep the fifo from ever refusing a returning line
  cso_line_fifo #(
    .WIDTH(`CSO_LINE_BITS),
    .DEPTH(`CSO_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .flush(flush),
    .in_valid(push && !flush),
    .in_ready(),
    .in_data(line_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .count(fifo_cnt)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cl_valid_q <= 1'b0;
      cl_data_q <= '0;
    end else if (flush) begin
      cl_valid_q <= 1'b0;
    end else if (stage_load) begin
      cl_valid_q <= fifo_out_valid;
      cl_data_q <= fifo_out_data;
    end
  end

  mem_order_a: assert property (@(posedge clock) disable iff (!rstn)
    take && mem_consumer && mem_block |=> !reg_wr_q && !cmd_done_q
      && (state_q == CSO_ST_WAIT_MEM))
    else $error("memory consumer ran ahead of pending writes");

  nonposted_wait_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_q == CSO_ST_WAIT_REG) && !reg_wr_ack |=> !cmd_done_q)
    else $error("command finished before register ack");

  np_types_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(reg_wr_q) && (cur_q != CSO_CMD_REG_LOAD_MEM) |-> !reg_wr_posted_q)
    else $error("non-posted command issued posted write");

  async_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    reg_wr_q && (cur_q == CSO_CMD_REG_LOAD_MEM) |-> reg_wr_posted_q == async_q
      && cmd_done_q == async_q)
    else $error("async bit not obeyed");

  fetch_credit_a: assert property (@(posedge clock) disable iff (!rstn)
    inflight + (`CSO_CNT_W + 1)'(fetch_req_q) <= (`CSO_CNT_W + 1)'(`CSO_FIFO_DEPTH))
    else $error("more than eight lines in flight");

  adv_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    jump_seen && !adv_pf_active_q && !flush && !hold_q |=> hold_q)
    else $error("fetch streamed across jump while disabled");

  jump_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    hold_q && !fetch_req_q && !jump_exec |=> !fetch_req_q)
    else $error("fetch issued while held at a jump");

  arb_ctx_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (cmd_type == CSO_CMD_ARB_CHECK) && !ctx_load |=> ctx_pf_en_q == $past(cmd_arb_pf_en)
      ##1 adv_pf_active_q == ($past(gpf_q) && $past(ctx_pf_en_q)))
    else $error("context prefetch enable not taken");

endmodule

`default_nettype wire

// ==== cso_consts.svh ====
// constants for the command-stream ordering and fetch block
// assumes inclusion by bare name from the package and the design modules
`ifndef CSO_CONSTS_SVH
`define CSO_CONSTS_SVH

`define CSO_FIFO_DEPTH 8
`define CSO_LINE_BYTES 64
`define CSO_LINE_BITS 512
`define CSO_ADDR_W 32
`define CSO_CNT_W 4
`define CSO_MEMPEND_W 6
`define CSO_GLOBAL_PF_RST 1'b1
`define CSO_CTX_PF_RST 1'b1

`endif

// ==== cso_pkg.sv ====
// types shared by the command-stream ordering and fetch block
// assumes cso_consts.svh sits in the same folder
`include "cso_consts.svh"

package cso_pkg;

  typedef enum logic [3:0] {
    CSO_CMD_OTHER,
    CSO_CMD_REG_LOAD_MEM,
    CSO_CMD_REG_LOAD_IMM,
    CSO_CMD_REG_COPY,
    CSO_CMD_MATH,
    CSO_CMD_PIPE_CTRL,
    CSO_CMD_ATOMIC,
    CSO_CMD_SEM_WAIT,
    CSO_CMD_BATCH_START,
    CSO_CMD_COND_BATCH_END,
    CSO_CMD_ARB_CHECK,
    CSO_CMD_REG_READER
  } cso_cmd_type;

  typedef enum logic [1:0] {
    CSO_ST_IDLE,
    CSO_ST_WAIT_MEM,
    CSO_ST_WAIT_REG
  } cso_state_type;

endpackage

// ==== cso_line_fifo.sv ====
// small valid/ready fifo that holds fetched command lines
// assumes a single clock; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "cso_consts.svh"

module cso_line_fifo #(
  parameter int WIDTH = `CSO_LINE_BITS,
  parameter int DEPTH = `CSO_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // occupancy
  output logic [`CSO_CNT_W-1:0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [`CSO_CNT_W-1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_q != `CSO_CNT_W'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + `CSO_CNT_W'(push) - `CSO_CNT_W'(pop);
    end
  end

  // the filler has no way to stall a returning line, so a full fifo here loses data
  fill_room_a: assert property (@(posedge clock) disable iff (!rstn)
    in_valid |-> in_ready)
    else $error("returning line found the fifo full");

endmodule

`default_nettype wire

// ==== cso_mem_model.sv ====
// graphics memory model answering command line fetches in grant order
// assumes the fetch request is held until granted; slow adds random stalls
`timescale 1ns/1ps
`default_nettype none
`include "cso_consts.svh"
module cso_mem_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  // fetch port
  input wire logic fetch_req_q,
  input wire logic [`CSO_ADDR_W-1:0] fetch_addr_q,
  output logic fetch_gnt,
  output logic line_valid,
  output logic [`CSO_LINE_BITS-1:0] line_data
);
  logic [`CSO_ADDR_W-1:0] pend[$];
  int seed = 46;
  initial begin
    fetch_gnt = 1'b0;
    line_valid = 1'b0;
    line_data = '0;
  end
  always @(posedge clock) begin
    if (fetch_req_q && fetch_gnt) pend.push_back(fetch_addr_q);
  end
  // data lines toggle outside a return so a stale line never looks fresh
  always @(negedge clock) begin
    fetch_gnt <= rstn && fetch_req_q && (!slow || $random(seed) % 3 == 0);
    line_valid <= 1'b0;
    line_data <= ~line_data;
    if (pend.size() > 0 && (!slow || $random(seed) % 2 == 0)) begin
      line_valid <= 1'b1;
      line_data <= {16{pend.pop_front() ^ 32'ha5a50000}};
    end
  end
endmodule
`default_nettype wire

// ==== cso_cmd_order_tb.sv ====
// self-checking bench for the command ordering gate and line fetch engine
// assumes cso_mem_model stands in for graphics memory on the fetch port
`timescale 1ns/1ps
`default_nettype none
`include "cso_consts.svh"
module cso_cmd_order_tb;
  import cso_pkg::*;
  logic clock = 0, rstn = 0, slow = 0, cmd_valid = 0, cmd_async = 0, cmd_arb_pf_en = 0;
  logic mem_wr_issue = 0, mem_wr_go = 0, reg_wr_ack = 0, gpf_wr = 0, gpf_wr_data = 0;
  logic ctx_load = 0, ctx_load_pf_en = 0, jump_seen = 0, jump_exec = 0, cl_ready = 0;
  logic drain = 0, redir = 0, ack_owed = 0, mem_cons;
  cso_cmd_type cmd_type = CSO_CMD_OTHER;
  cso_cmd_type cons[3] = '{CSO_CMD_REG_LOAD_MEM, CSO_CMD_ATOMIC, CSO_CMD_SEM_WAIT};
  logic [`CSO_ADDR_W-1:0] jump_tgt = '0, exp_addr = '0, fetch_addr_q;
  logic cmd_done_q, reg_wr_q, reg_wr_posted_q, ctx_pf_en_q, adv_pf_active_q;
  logic fetch_req_q, fetch_gnt, line_valid, cl_valid_q;
  logic [`CSO_LINE_BITS-1:0] line_data, cl_data_q;
  logic exp_q[$];
  logic [`CSO_LINE_BITS-1:0] exp_line[$];
  int err_total = 0, n_checks = 0, seed = 46, inflight = 0, n_gnt = 0, pend_w = 0;
  int ack_cnt = 0, g;
  always #5 clock = ~clock;
  assign mem_cons = cmd_type inside {CSO_CMD_REG_LOAD_MEM, CSO_CMD_ATOMIC, CSO_CMD_SEM_WAIT};
  cso_cmd_order dut_u (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_type(cmd_type), .cmd_async(cmd_async), .cmd_arb_pf_en(cmd_arb_pf_en),
    .cmd_done_q(cmd_done_q), .mem_wr_issue(mem_wr_issue), .mem_wr_go(mem_wr_go),
    .reg_wr_q(reg_wr_q), .reg_wr_posted_q(reg_wr_posted_q), .reg_wr_ack(reg_wr_ack),
    .gpf_wr(gpf_wr), .gpf_wr_data(gpf_wr_data), .ctx_load(ctx_load),
    .ctx_load_pf_en(ctx_load_pf_en), .ctx_pf_en_q(ctx_pf_en_q),
    .adv_pf_active_q(adv_pf_active_q), .jump_seen(jump_seen), .jump_seen_tgt(jump_tgt),
    .jump_exec(jump_exec), .jump_exec_tgt(jump_tgt), .fetch_req_q(fetch_req_q),
    .fetch_addr_q(fetch_addr_q), .fetch_gnt(fetch_gnt), .line_valid(line_valid),
    .line_data(line_data), .cl_valid_q(cl_valid_q), .cl_data_q(cl_data_q),
    .cl_ready(cl_ready));
  cso_mem_model mem_u (.clock(clock), .rstn(rstn), .slow(slow), .fetch_req_q(fetch_req_q),
    .fetch_addr_q(fetch_addr_q), .fetch_gnt(fetch_gnt), .line_valid(line_valid),
    .line_data(line_data));
  task automatic chk(string what, logic [`CSO_LINE_BITS-1:0] exp,
                     logic [`CSO_LINE_BITS-1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic run_cmd(cso_cmd_type t, logic a, logic pf);
    int n;
    if (t inside {CSO_CMD_REG_LOAD_MEM, CSO_CMD_REG_LOAD_IMM, CSO_CMD_REG_COPY,
                  CSO_CMD_MATH, CSO_CMD_PIPE_CTRL})
      exp_q.push_back(t == CSO_CMD_REG_LOAD_MEM && a);
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_async = a;
    cmd_arb_pf_en = pf;
    tick(1);
    for (n = 0; n < 200 && cmd_done_q !== 1'b1; n++) tick(1);
    chk("command done", 1, cmd_done_q);
    cmd_valid = 1'b0;
    tick(1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // expected results are noted by the drivers and taken off here as outputs appear
  always @(posedge clock) begin
    if (rstn) begin
      pend_w = pend_w + int'(mem_wr_issue) - int'(mem_wr_go);
      if (reg_wr_ack) ack_owed = 1'b0;
      if (reg_wr_q && exp_q.size() == 0) chk("unexpected reg write", 0, 1);
      if (reg_wr_q && exp_q.size() > 0) chk("posted", exp_q.pop_front(), reg_wr_posted_q);
      if (reg_wr_q && reg_wr_posted_q) chk("posted done", 1, cmd_done_q);
      if (reg_wr_q && !reg_wr_posted_q) ack_owed = 1'b1;
      if (cmd_done_q) chk("done before ack", 0, ack_owed);
      if (cmd_done_q && mem_cons) chk("writes pending", 0, pend_w != 0);
      if (fetch_req_q && fetch_gnt) begin
        if (redir && fetch_addr_q === jump_tgt) exp_addr = jump_tgt;
        if (redir && fetch_addr_q === jump_tgt) redir = 1'b0;
        chk("fetch room", 1, inflight - int'(cl_valid_q) < 8);
        chk("fetch address", exp_addr, fetch_addr_q);
        exp_line.push_back({16{exp_addr ^ 32'ha5a50000}});
        exp_addr = exp_addr + 32'h40;
        inflight++;
        n_gnt++;
      end
      if (cl_valid_q && cl_ready) begin
        chk("line data", exp_line.size() ? exp_line.pop_front() : '0, cl_data_q);
        inflight--;
      end
      if (jump_seen && adv_pf_active_q) redir = 1'b1;
      if (jump_exec && !adv_pf_active_q) begin
        exp_line.delete();
        inflight = 0;
        exp_addr = jump_tgt;
      end
    end
  end
  always @(negedge clock) begin
    reg_wr_ack <= ack_cnt == 1;
    if (ack_cnt > 0) ack_cnt--;
    if (reg_wr_q && !reg_wr_posted_q) ack_cnt = 2 + {$random(seed)} % 4;
    cl_ready <= drain && $random(seed) % 2 == 0;
    slow <= $random(seed) % 4 == 0;
  end
  initial begin
    #200000;
    err_total++;
    end_sim;
  end
  initial begin
    tick(5);
    rstn = 1'b1;
    tick(1);
    chk("adv after reset", 1, adv_pf_active_q);
    chk("ctx after reset", 1, ctx_pf_en_q);
    for (int i = 0; i < 14; i++) run_cmd(cso_cmd_type'(i % 12), i == 12, 1);
    run_cmd(CSO_CMD_REG_LOAD_MEM, 1'b1, 1'b1);
    chk("fifo fill", 8, inflight - int'(cl_valid_q));
    $display("test commands and fill finished");
    foreach (cons[i]) begin
      pulse(mem_wr_issue);
      pulse(mem_wr_issue);
      fork
        run_cmd(cons[i], 1'b0, 1'b1);
        begin
          tick(12);
          pulse(mem_wr_go);
          tick(3);
          pulse(mem_wr_go);
        end
      join
    end
    pulse(mem_wr_issue);
    run_cmd(CSO_CMD_COND_BATCH_END, 1'b0, 1'b1);
    pulse(mem_wr_go);
    $display("test memory ordering finished");
    run_cmd(CSO_CMD_ARB_CHECK, 1'b0, 1'b0);
    tick(2);
    chk("ctx cleared", 0, ctx_pf_en_q);
    chk("adv off by ctx", 0, adv_pf_active_q);
    run_cmd(CSO_CMD_ARB_CHECK, 1'b0, 1'b1);
    gpf_wr_data = 1'b0;
    pulse(gpf_wr);
    chk("ctx kept", 1, ctx_pf_en_q);
    chk("adv off by global", 0, adv_pf_active_q);
    gpf_wr_data = 1'b1;
    pulse(gpf_wr);
    ctx_load_pf_en = 1'b0;
    pulse(ctx_load);
    chk("ctx restored", 0, ctx_pf_en_q);
    $display("test enables finished");
    drain = 1'b1;
    tick(40);
    jump_tgt = 32'h4000;
    pulse(jump_seen);
    tick(5);
    g = n_gnt;
    tick(30);
    chk("fetch held", g, n_gnt);
    drain = 1'b0;
    tick(2);
    pulse(jump_exec);
    drain = 1'b1;
    tick(80);
    run_cmd(CSO_CMD_ARB_CHECK, 1'b0, 1'b1);
    tick(2);
    jump_tgt = 32'h8000;
    pulse(jump_seen);
    tick(100);
    chk("adv redirect", 0, redir);
    $display("test jumps finished");
    end_sim;
  end
endmodule
`default_nettype wire
